// File: hdl/nfcm_pkg.sv
/*
 * nfcm_pkg: constants and types of the front-end mode control block.
 * Assumes a single 125 MHz system clock domain; host pins enter asynchronously.
 */
package nfcm_pkg;

	// ------------------------------------------------------------
	// register offsets on the host serial port
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_OPCTL   = 6'h00;
	localparam logic [5:0] ADDR_IOCFG1  = 6'h01;
	localparam logic [5:0] ADDR_IOCFG2  = 6'h02;
	localparam logic [5:0] ADDR_WUCFG   = 6'h03;
	localparam logic [5:0] ADDR_AMPREF  = 6'h04;
	localparam logic [5:0] ADDR_PHSREF  = 6'h05;
	localparam logic [5:0] ADDR_IRQMASK = 6'h06;
	localparam logic [5:0] ADDR_IRQSTAT = 6'h07;
	localparam logic [5:0] ADDR_ID0     = 6'h08;
	localparam logic [5:0] ADDR_ID1     = 6'h09;
	localparam logic [5:0] ADDR_ID2     = 6'h0A;
	localparam logic [5:0] ADDR_ID3     = 6'h0B;
	localparam logic [5:0] RAM_BYTES    = 6'h30;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int OPC_EN_BIT    = 7;
	localparam int OPC_RX_BIT    = 6;
	localparam int OPC_TX_BIT    = 3;
	localparam int OPC_WAKE_BIT  = 2;
	localparam int IO1_ALT_BIT   = 0;
	localparam int IO1_SINGLE_BIT = 1;
	localparam int WAKE_AMP_BIT  = 4;
	localparam int WAKE_PHS_BIT  = 5;
	localparam int IRQ_OSC_BIT   = 0;
	localparam int IRQ_AMP_BIT   = 1;
	localparam int IRQ_PHS_BIT   = 2;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] OPCTL_RST   = 8'h00;
	localparam logic [7:0] CFG_RST     = 8'h00;
	localparam logic [7:0] IRQMASK_RST = 8'h07;
	localparam logic [7:0] WAKE_TICK_LOW = 8'hFF;
	localparam logic [4:0] CMD_LAST    = 5'h07;
	localparam logic [4:0] DATA_LAST   = 5'h0F;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_POWER_DOWN,
		MODE_READY,
		MODE_WAKEUP
	} nfcm_mode_type;

	// first byte of every serial frame
	typedef struct packed {
		logic       read;
		logic       ram;
		logic [5:0] addr;
	} nfcm_cmd_type;

endpackage

// File: hdl/nfcm_mode_control.sv
/*
 * nfcm_mode_control: operating mode, start-up and host access control of a
 * contactless reader front end, with a four-wire serial register port.
 * Assumes analog blocks (crystal, RC oscillator, measurement unit) outside;
 * host pins and the RC clock are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

module nfcm_mode_control #(
	parameter logic [7:0] FACTORY_WAFER   = 8'h5A, // arbitrary value
	parameter logic [7:0] FACTORY_DIE_POS = 8'h3C, // arbitrary value
	parameter logic [7:0] FACTORY_SUBVER  = 8'h01, // arbitrary value
	parameter logic [7:0] FACTORY_BUS_ADR = 8'h42  // arbitrary value
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// host serial pins
	input  wire logic       sclk_in,
	input  wire logic       serial_select_n_in,
	input  wire logic       mosi_in,
	input  wire logic       i2c_enable_in,
	output logic            miso_out,
	output logic            miso_oe_out,
	output logic            irq_out,
	// analog status
	input  wire logic       osc_stable_in,
	input  wire logic       rc_clk_in,
	// measurement unit, same clock
	input  wire logic       meas_done_in,
	input  wire logic [7:0] meas_value_in,
	// power and rf controls
	output logic            osc_enable_out,
	output logic            regulator_enable_out,
	output logic            rc_osc_enable_out,
	output logic            rx_enable_out,
	output logic            tx_enable_out,
	output logic            antenna_driver_out_a_enable_out,
	output logic            antenna_driver_out_b_enable_out,
	output logic            rx_input_b_select_out,
	output logic            i2c_mode_out,
	output logic            fifo_access_out,
	output logic            measure_start_out,
	output logic            measure_phase_out,
	output logic [7:0]      io_config2_out,
	output logic [1:0]      mode_out
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [5:0] pin_meta_reg;
	logic [5:0] pin_sync_reg;
	logic       sclk_prev_reg;
	logic       rc_prev_reg;
	logic       osc_prev_reg;
	wire  [5:0] pin_raw = {rc_clk_in, osc_stable_in, i2c_enable_in, mosi_in, serial_select_n_in, sclk_in};

	// first stage feeds only the second stage
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pin_meta_reg  <= 6'h02;
			pin_sync_reg  <= 6'h02;
			sclk_prev_reg <= 1'b0;
			rc_prev_reg   <= 1'b0;
			osc_prev_reg  <= 1'b0;
		end else begin
			pin_meta_reg  <= pin_raw;
			pin_sync_reg  <= pin_meta_reg;
			sclk_prev_reg <= pin_sync_reg[0];
			rc_prev_reg   <= pin_sync_reg[5];
			osc_prev_reg  <= pin_sync_reg[4];
		end
	end

	wire sclk_s    = pin_sync_reg[0];
	wire ssn_s     = pin_sync_reg[1];
	wire mosi_s    = pin_sync_reg[2];
	wire i2c_s     = pin_sync_reg[3];
	wire osc_s     = pin_sync_reg[4];
	wire rc_s      = pin_sync_reg[5];
	wire sclk_rise = sclk_s & ~sclk_prev_reg;
	wire sclk_fall = ~sclk_s & sclk_prev_reg;
	wire rc_rise   = rc_s & ~rc_prev_reg;
	wire osc_rise  = osc_s & ~osc_prev_reg;

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [7:0]            opctl_reg;
	logic [7:0]            iocfg1_reg;
	logic [7:0]            iocfg2_reg;
	logic [7:0]            wucfg_reg;
	logic [7:0]            ampref_reg;
	logic [7:0]            phsref_reg;
	logic [7:0]            irqmask_reg;
	logic [7:0]            irqstat_reg;
	logic [7:0]            target_config_ram [0:47];
	nfcm_pkg::nfcm_mode_type mode_reg;
	logic [4:0]            bit_cnt_reg;
	logic [7:0]            rx_shift_reg;
	logic [7:0]            tx_shift_reg;
	nfcm_pkg::nfcm_cmd_type cmd_reg;
	logic [11:0]           wake_cnt_reg;
	logic                  meas_busy_reg;
	logic                  meas_phase_reg;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	wire opc_en   = opctl_reg[nfcm_pkg::OPC_EN_BIT];
	wire [7:0] wake_only = 8'h01 << nfcm_pkg::OPC_WAKE_BIT;
	wire is_wake  = (opctl_reg == wake_only);
	wire ready    = (mode_reg == nfcm_pkg::MODE_READY);
	wire waking   = (mode_reg == nfcm_pkg::MODE_WAKEUP);
	nfcm_pkg::nfcm_mode_type mode_next;
	assign mode_next = opc_en ? nfcm_pkg::MODE_READY :
		(is_wake ? nfcm_pkg::MODE_WAKEUP : nfcm_pkg::MODE_POWER_DOWN);

	// ------------------------------------------------------------
	// serial frame decode
	// ------------------------------------------------------------
	// the port stays alive in every mode, only the protocol select gates it
	wire spi_on    = ~ssn_s & ~i2c_s;
	wire [7:0] rx_byte_next = {rx_shift_reg[6:0], mosi_s};
	wire cmd_done  = spi_on & sclk_rise & (bit_cnt_reg == nfcm_pkg::CMD_LAST);
	wire data_done = spi_on & sclk_rise & (bit_cnt_reg == nfcm_pkg::DATA_LAST);
	nfcm_pkg::nfcm_cmd_type cmd_now;
	assign cmd_now = nfcm_pkg::nfcm_cmd_type'(rx_byte_next);
	wire ram_rd_hit = cmd_now.addr < nfcm_pkg::RAM_BYTES;
	wire ram_wr_hit = cmd_reg.addr < nfcm_pkg::RAM_BYTES;
	wire wr_strobe  = data_done & ~cmd_reg.read & ~cmd_reg.ram;
	// ram writes outside ready mode are silently dropped
	wire ram_wr     = data_done & ~cmd_reg.read & cmd_reg.ram & ready & ram_wr_hit;
	wire stat_clr   = cmd_done & cmd_now.read & ~cmd_now.ram & (cmd_now.addr == nfcm_pkg::ADDR_IRQSTAT);

	// register read selection
	logic [7:0] reg_rd;
	always_comb begin
		case (cmd_now.addr)
			nfcm_pkg::ADDR_OPCTL:   reg_rd = opctl_reg;
			nfcm_pkg::ADDR_IOCFG1:  reg_rd = iocfg1_reg;
			nfcm_pkg::ADDR_IOCFG2:  reg_rd = iocfg2_reg;
			nfcm_pkg::ADDR_WUCFG:   reg_rd = wucfg_reg;
			nfcm_pkg::ADDR_AMPREF:  reg_rd = ampref_reg;
			nfcm_pkg::ADDR_PHSREF:  reg_rd = phsref_reg;
			nfcm_pkg::ADDR_IRQMASK: reg_rd = irqmask_reg;
			nfcm_pkg::ADDR_IRQSTAT: reg_rd = irqstat_reg;
			nfcm_pkg::ADDR_ID0:     reg_rd = FACTORY_WAFER;
			nfcm_pkg::ADDR_ID1:     reg_rd = FACTORY_DIE_POS;
			nfcm_pkg::ADDR_ID2:     reg_rd = FACTORY_SUBVER;
			nfcm_pkg::ADDR_ID3:     reg_rd = FACTORY_BUS_ADR;
			default:                reg_rd = 8'h00;
		endcase
	end

	// ram reads in power-down answer zero
	wire ram_rd_ok   = ready & ram_rd_hit;
	wire [7:0] ram_q = ram_rd_ok ? target_config_ram[cmd_now.addr] : 8'h00;
	wire [7:0] rd_data = cmd_now.ram ? ram_q : reg_rd;

	// ------------------------------------------------------------
	// serial shift engine
	// ------------------------------------------------------------
	// count restarts whenever select goes high between frames
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bit_cnt_reg  <= 5'h00;
			rx_shift_reg <= 8'h00;
			cmd_reg      <= '0;
		end else if (!spi_on) begin
			bit_cnt_reg  <= 5'h00;
		end else if (sclk_rise) begin
			bit_cnt_reg  <= bit_cnt_reg + 5'h01;
			rx_shift_reg <= rx_byte_next;
			if (cmd_done)
				cmd_reg <= cmd_now;
		end
	end

	// data out changes on the falling edge, so it is settled at the next rise
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tx_shift_reg <= 8'h00;
			miso_out     <= 1'b0;
			miso_oe_out  <= 1'b0;
		end else begin
			if (cmd_done)
				tx_shift_reg <= rd_data;
			else if (spi_on & sclk_fall) begin
				miso_out     <= tx_shift_reg[7];
				tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
			end
			miso_oe_out <= spi_on & cmd_reg.read & bit_cnt_reg[3];
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// every register takes its default at reset, so start-up is power-down
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			opctl_reg   <= nfcm_pkg::OPCTL_RST;
			iocfg1_reg  <= nfcm_pkg::CFG_RST;
			iocfg2_reg  <= nfcm_pkg::CFG_RST;
			wucfg_reg   <= nfcm_pkg::CFG_RST;
			ampref_reg  <= nfcm_pkg::CFG_RST;
			phsref_reg  <= nfcm_pkg::CFG_RST;
			irqmask_reg <= nfcm_pkg::IRQMASK_RST;
			mode_reg    <= nfcm_pkg::MODE_POWER_DOWN;
		end else begin
			mode_reg <= mode_next;
			if (wr_strobe) begin
				case (cmd_reg.addr)
					nfcm_pkg::ADDR_OPCTL:   opctl_reg   <= rx_byte_next;
					nfcm_pkg::ADDR_IOCFG1:  iocfg1_reg  <= rx_byte_next;
					nfcm_pkg::ADDR_IOCFG2:  iocfg2_reg  <= rx_byte_next;
					nfcm_pkg::ADDR_WUCFG:   wucfg_reg   <= rx_byte_next;
					nfcm_pkg::ADDR_AMPREF:  ampref_reg  <= rx_byte_next;
					nfcm_pkg::ADDR_PHSREF:  phsref_reg  <= rx_byte_next;
					nfcm_pkg::ADDR_IRQMASK: irqmask_reg <= rx_byte_next;
					default: ;
				endcase
			end
		end
	end

	// target ram has no reset; its content is only meaningful once written
	always_ff @(posedge clk_in) begin
		if (ram_wr)
			target_config_ram[cmd_reg.addr] <= rx_byte_next;
	end

	// ------------------------------------------------------------
	// wake-up timer and measurement scheduling
	// ------------------------------------------------------------
	wire amp_en   = wucfg_reg[nfcm_pkg::WAKE_AMP_BIT];
	wire phs_en   = wucfg_reg[nfcm_pkg::WAKE_PHS_BIT];
	wire [11:0] wake_limit = {wucfg_reg[3:0], nfcm_pkg::WAKE_TICK_LOW};
	wire wake_expire = waking & rc_rise & (wake_cnt_reg == wake_limit);
	// with both triggers on, the two kinds alternate period by period
	wire next_phase = (amp_en & phs_en) ? ~meas_phase_reg : phs_en;
	wire start_meas = wake_expire & (amp_en | phs_en) & ~meas_busy_reg;

	// timer advances only on RC clock edges, never on the crystal
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wake_cnt_reg   <= 12'h000;
			meas_busy_reg  <= 1'b0;
			meas_phase_reg <= 1'b0;
		end else begin
			if (!waking || wake_expire)
				wake_cnt_reg <= 12'h000;
			else if (rc_rise)
				wake_cnt_reg <= wake_cnt_reg + 12'h001;
			if (start_meas) begin
				meas_busy_reg  <= 1'b1;
				meas_phase_reg <= next_phase;
			end else if (meas_done_in || !waking)
				meas_busy_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// interrupt sources
	// ------------------------------------------------------------
	wire meas_end  = meas_done_in & meas_busy_reg & waking;
	wire amp_diff  = meas_end & ~meas_phase_reg & (meas_value_in != ampref_reg);
	wire phs_diff  = meas_end & meas_phase_reg & (meas_value_in != phsref_reg);
	wire osc_event = opc_en & osc_rise;
	wire [7:0] irq_set = ({7'h00, osc_event} << nfcm_pkg::IRQ_OSC_BIT)
		| ({7'h00, amp_diff} << nfcm_pkg::IRQ_AMP_BIT)
		| ({7'h00, phs_diff} << nfcm_pkg::IRQ_PHS_BIT);
	// a new event in the clearing cycle survives the clear
	wire [7:0] irqstat_next = (stat_clr ? 8'h00 : irqstat_reg) | irq_set;

	// status clears on read; the line follows masked pending bits
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irqstat_reg <= 8'h00;
			irq_out     <= 1'b0;
		end else begin
			irqstat_reg <= irqstat_next;
			irq_out     <= |(irqstat_next & irqmask_reg);
		end
	end

	// ------------------------------------------------------------
	// power and rf control outputs
	// ------------------------------------------------------------
	wire single   = iocfg1_reg[nfcm_pkg::IO1_SINGLE_BIT];
	wire alt_sel  = iocfg1_reg[nfcm_pkg::IO1_ALT_BIT];
	wire tx_on    = ready & opctl_reg[nfcm_pkg::OPC_TX_BIT];
	wire rx_on    = ready & opctl_reg[nfcm_pkg::OPC_RX_BIT];
	wire drv_a    = tx_on & (~single | ~alt_sel);
	wire drv_b    = tx_on & (~single | alt_sel);

	// all controls registered so the pins never glitch on decode
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			osc_enable_out                  <= 1'b0;
			regulator_enable_out            <= 1'b0;
			rc_osc_enable_out               <= 1'b0;
			rx_enable_out                   <= 1'b0;
			tx_enable_out                   <= 1'b0;
			antenna_driver_out_a_enable_out <= 1'b0;
			antenna_driver_out_b_enable_out <= 1'b0;
			rx_input_b_select_out           <= 1'b0;
			i2c_mode_out                    <= 1'b0;
			fifo_access_out                 <= 1'b0;
			measure_start_out               <= 1'b0;
			measure_phase_out               <= 1'b0;
			io_config2_out                  <= 8'h00;
			mode_out                        <= 2'h0;
		end else begin
			osc_enable_out                  <= ready;
			regulator_enable_out            <= ready;
			rc_osc_enable_out               <= waking;
			rx_enable_out                   <= rx_on;
			tx_enable_out                   <= tx_on;
			antenna_driver_out_a_enable_out <= drv_a;
			antenna_driver_out_b_enable_out <= drv_b;
			rx_input_b_select_out           <= single & alt_sel;
			i2c_mode_out                    <= i2c_s;
			fifo_access_out                 <= ready;
			measure_start_out               <= start_meas;
			measure_phase_out               <= start_meas ? next_phase : meas_phase_reg;
			io_config2_out                  <= iocfg2_reg;
			mode_out                        <= mode_reg;
		end
	end

endmodule

`default_nettype wire

// File: testbench/nfcm_checker.sv
/*
 * nfcm_checker: port-level assertions for nfcm_mode_control.
 * Assumes one clock domain with a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module nfcm_checker (
	// clock, reset and pins
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       serial_select_n_in,
	input wire logic       i2c_enable_in,
	input wire logic       osc_stable_in,
	// controls watched
	input wire logic       irq_out,
	input wire logic       miso_oe_out,
	input wire logic       osc_enable_out,
	input wire logic       regulator_enable_out,
	input wire logic       rc_osc_enable_out,
	input wire logic       tx_enable_out,
	input wire logic       antenna_driver_out_a_enable_out,
	input wire logic       antenna_driver_out_b_enable_out,
	input wire logic       i2c_mode_out,
	input wire logic       fifo_access_out,
	input wire logic       measure_start_out,
	input wire logic [1:0] mode_out
);
	// ----------------------------------------
	// mode and control relations
	// ----------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_reset_idle;
		$fell(rst_in) |-> mode_out == 2'h0 && !osc_enable_out && !tx_enable_out && !irq_out;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
	property p_ready;
		osc_enable_out == (mode_out == 2'h1) && regulator_enable_out == osc_enable_out;
	endproperty
	a_ready: assert property (p_ready) else $error("oscillator or regulator wrong for mode");
	property p_fifo;
		fifo_access_out == (mode_out == 2'h1);
	endproperty
	a_fifo: assert property (p_fifo) else $error("fifo access wrong for mode");
	property p_wake;
		rc_osc_enable_out == (mode_out == 2'h2);
	endproperty
	a_wake: assert property (p_wake) else $error("rc oscillator wrong for mode");
	property p_ant;
		(antenna_driver_out_a_enable_out || antenna_driver_out_b_enable_out) == tx_enable_out;
	endproperty
	a_ant: assert property (p_ant) else $error("antenna drivers disagree with transmitter");
	property p_meas;
		measure_start_out |-> rc_osc_enable_out ##1 !measure_start_out;
	endproperty
	a_meas: assert property (p_meas) else $error("bad measurement start pulse");
	// the pin passes a synchroniser, hence the window
	property p_osc_irq;
		osc_enable_out && $rose(osc_stable_in) |-> ##[1:8] irq_out;
	endproperty
	a_osc_irq: assert property (p_osc_irq) else $error("no irq after oscillator stable");
	property p_irq_hold;
		$fell(irq_out) |-> !$past(serial_select_n_in, 4);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped outside a host frame");
	property p_i2c;
		$rose(i2c_enable_in) |-> ##[1:6] i2c_mode_out;
	endproperty
	a_i2c: assert property (p_i2c) else $error("protocol select not followed");
	// the data line may only be driven inside a selected four-wire frame
	property p_oe;
		miso_oe_out |-> !$past(serial_select_n_in, 3) && !$past(i2c_enable_in, 3);
	endproperty
	a_oe: assert property (p_oe) else $error("data line driven outside a frame");
endmodule

bind nfcm_mode_control nfcm_checker i_nfcm_checker (
	.clk_in, .rst_in, .serial_select_n_in, .i2c_enable_in, .osc_stable_in, .irq_out, .miso_oe_out, .osc_enable_out,
	.regulator_enable_out, .rc_osc_enable_out, .tx_enable_out, .antenna_driver_out_a_enable_out,
	.antenna_driver_out_b_enable_out, .i2c_mode_out, .fifo_access_out, .measure_start_out, .mode_out);
`default_nettype wire

// File: testbench/nfcm_host_model.sv
/*
 * nfcm_host_model: behavioural host on the four-wire serial port, mode 0.
 * Assumes the bench clock paces it; frames are started by calling xfer.
 */
`timescale 1ns/1ps
`default_nettype none

module nfcm_host_model (
	// clock and serial pins
	input  wire logic       clk_in,
	input  wire logic       miso_in,
	output logic            sclk_out,
	output logic            select_n_out,
	output logic            mosi_out,
	// captured read byte
	output logic            rd_valid_out,
	output logic [7:0]      rd_data_out
);
	// ----------------------------------------
	// frame engine
	// ----------------------------------------
	localparam int HALF = 10; // 80 ns half period
	logic [23:0] shift_reg;

	// idle: serial clock parked low, select high
	initial begin
		sclk_out = 1'b0;
		select_n_out = 1'b1;
		mosi_out = 1'b0;
		rd_valid_out = 1'b0;
		rd_data_out = 8'h00;
		shift_reg = 24'h000000;
	end

	// msb first; data changes on the fall, is sampled on the rise
	task automatic xfer(input logic [23:0] frame, input int nbits);
		@(posedge clk_in);
		select_n_out <= 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			mosi_out <= frame[i];
			repeat (HALF) @(posedge clk_in);
			sclk_out <= 1'b1;
			shift_reg[i] <= miso_in;
			repeat (HALF) @(posedge clk_in);
			sclk_out <= 1'b0;
		end
		repeat (HALF) @(posedge clk_in);
		// released data line flips so a stale level never looks valid
		select_n_out <= 1'b1;
		mosi_out <= ~mosi_out;
		rd_valid_out <= (nbits == 16) && frame[15];
		rd_data_out <= shift_reg[7:0];
		@(posedge clk_in);
		rd_valid_out <= 1'b0;
		repeat (HALF) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
/*
 * tb_top: self-checking bench for nfcm_mode_control.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ----------------------------------------
	// tables and signals
	// ----------------------------------------
	localparam logic [7:0] ID [4]  = '{8'h11, 8'h22, 8'h33, 8'h44}; // arbitrary identity bytes
	localparam logic [7:0] OPC [6] = '{8'h04, 8'h0C, 8'h48, 8'hC0, 8'h80, 8'h88};
	localparam logic [7:0] PWR [6] = '{8'h88, 8'h00, 8'h00, 8'h75, 8'h71, 8'h73};
	localparam logic [7:0] IO1 [3] = '{8'h00, 8'h02, 8'h03};
	localparam logic [7:0] ANT [3] = '{8'h06, 8'h04, 8'h03};
	localparam logic [7:0] WCF [3] = '{8'h10, 8'h10, 8'h20};
	localparam logic [7:0] WST [3] = '{8'h00, 8'h02, 8'h04};
	logic       clk_in = 1'b0, rst_in = 1'b1, rc_clk = 1'b0, i2c_en = 1'b0, osc_ok = 1'b0, meas_done = 1'b0;
	logic [7:0] meas_val = 8'h00, io2, rd_data;
	logic       sclk, sel_n, mosi, miso, irq, osc_en, reg_en, rc_en, rx_en, tx_en, ant_a, ant_b, rxb;
	logic       i2c_mode, fifo_ok, m_start, m_phase, rd_valid;
	logic [1:0] mode;
	logic [7:0] exp_q [$];
	int         miscompares = 0, num_checks = 0;

	nfcm_mode_control #(.FACTORY_WAFER(ID[0]), .FACTORY_DIE_POS(ID[1]), .FACTORY_SUBVER(ID[2]),
		.FACTORY_BUS_ADR(ID[3])) i_nfcm_mode_control (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
		.serial_select_n_in(sel_n), .mosi_in(mosi), .i2c_enable_in(i2c_en), .miso_out(miso), .miso_oe_out(),
		.irq_out(irq), .osc_stable_in(osc_ok), .rc_clk_in(rc_clk), .meas_done_in(meas_done),
		.meas_value_in(meas_val), .osc_enable_out(osc_en), .regulator_enable_out(reg_en),
		.rc_osc_enable_out(rc_en), .rx_enable_out(rx_en), .tx_enable_out(tx_en),
		.antenna_driver_out_a_enable_out(ant_a), .antenna_driver_out_b_enable_out(ant_b),
		.rx_input_b_select_out(rxb), .i2c_mode_out(i2c_mode), .fifo_access_out(fifo_ok),
		.measure_start_out(m_start), .measure_phase_out(m_phase), .io_config2_out(io2), .mode_out(mode));
	nfcm_host_model i_nfcm_host_model (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk),
		.select_n_out(sel_n), .mosi_out(mosi), .rd_valid_out(rd_valid), .rd_data_out(rd_data));

	// system clock, and an rc clock out of phase with it
	always #4 clk_in = ~clk_in;
	initial begin
		#3;
		forever #80 rc_clk = ~rc_clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] ca, input logic [7:0] d);
		i_nfcm_host_model.xfer({8'h00, 1'b0, ca, d}, 16);
		repeat (4) @(posedge clk_in);
	endtask
	task automatic rd(input logic [6:0] ca, input logic [7:0] e);
		exp_q.push_back(e);
		i_nfcm_host_model.xfer({8'h00, 1'b1, ca, 8'h00}, 16);
	endtask
	task automatic test_done;
		cmp("pending reads", 8'h00, 8'(exp_q.size()));
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// read monitor: oldest note against each byte read back
	always @(posedge clk_in) begin
		if (rd_valid === 1'b1)
			cmp("read data", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX, rd_data);
	end

	// watchdog at about three and a half times the expected run
	initial begin
		repeat (100000) @(posedge clk_in);
		miscompares++;
		test_done;
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		int n;
		logic [7:0] d;
		void'($urandom(90));
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		i_nfcm_host_model.xfer(24'hFC0410, 24);
		wr(7'h01, 8'h00);
		wr(7'h02, 8'hA5);
		@(negedge clk_in);
		cmp("io config 2", 8'hA5, io2);
		rd(7'h00, 8'h00);
		rd(7'h06, 8'h07);
		for (int i = 0; i < 4; i++) rd(7'h08 + 7'(i), ID[i]);
		wr(7'h08, 8'hFF);
		rd(7'h08, ID[0]);
		wr(7'h45, 8'h3C);
		rd(7'h45, 8'h00);
		$display("test defaults done");
		for (int i = 0; i < 6; i++) begin
			wr(7'h00, OPC[i]);
			@(negedge clk_in);
			cmp("power outputs", PWR[i], {mode, osc_en, reg_en, rc_en, rx_en, tx_en, fifo_ok});
		end
		for (int i = 0; i < 3; i++) begin
			wr(7'h01, IO1[i]);
			@(negedge clk_in);
			cmp("antenna", ANT[i], {5'h00, ant_a, ant_b, rxb});
		end
		d = 8'($urandom);
		wr(7'h45, d);
		rd(7'h45, d);
		wr(7'h6F, ~d);
		rd(7'h6F, ~d);
		wr(7'h70, d);
		rd(7'h70, 8'h00);
		@(posedge clk_in) osc_ok <= 1'b1;
		repeat (10) @(negedge clk_in);
		cmp("irq", 8'h01, {7'h00, irq});
		// masking the pending source drops the line, unmasking brings it back
		wr(7'h06, 8'h06);
		@(negedge clk_in);
		cmp("irq", 8'h00, {7'h00, irq});
		wr(7'h06, 8'h07);
		@(negedge clk_in);
		cmp("irq", 8'h01, {7'h00, irq});
		rd(7'h07, 8'h01);
		@(negedge clk_in);
		cmp("irq", 8'h00, {7'h00, irq});
		@(posedge clk_in) osc_ok <= 1'b0;
		$display("test ready mode done");
		// wake-up: equal amplitude, differing amplitude, differing phase
		wr(7'h04, 8'h5A);
		wr(7'h05, 8'hC3);
		wr(7'h03, WCF[0]);
		wr(7'h00, 8'h04);
		for (int k = 0; k < 3; k++) begin
			if (k > 0) wr(7'h03, WCF[k]);
			n = 0;
			do @(negedge clk_in); while (m_start !== 1'b1 && n++ < 7000);
			cmp("measure start", {6'h00, 1'b1, WCF[k][5]}, {6'h00, m_start, m_phase});
			@(posedge clk_in);
			meas_done <= 1'b1;
			meas_val <= (WCF[k][5] ? 8'hC3 : 8'h5A) ^ ((k > 0) ? (8'h01 | 8'($urandom)) : 8'h00);
			@(posedge clk_in) meas_done <= 1'b0;
			repeat (6) @(negedge clk_in);
			cmp("irq", {7'h00, k > 0}, {7'h00, irq});
			rd(7'h07, WST[k]);
		end
		$display("test wakeup done");
		wr(7'h00, 8'h00);
		@(posedge clk_in) i2c_en <= 1'b1;
		repeat (8) @(negedge clk_in);
		cmp("i2c mode", 8'h01, {7'h00, i2c_mode});
		wr(7'h00, 8'h80);
		@(negedge clk_in);
		cmp("power outputs", 8'h00, {mode, osc_en, reg_en, rc_en, rx_en, tx_en, fifo_ok});
		@(posedge clk_in) i2c_en <= 1'b0;
		repeat (8) @(posedge clk_in);
		$display("test protocol select done");
		test_done;
	end
endmodule
`default_nettype wire
